// ### logic/regmon_map.svh
// constants of the regulator voltage monitor: offsets, fields, reset values, timing
`ifndef REGMON_MAP_SVH
`define REGMON_MAP_SVH

`define NUM_CH 4
`define CORE_CLK_HZ 40000000
`define LOGIC_CLK_HZ 100000
`define TICK_DIV (`CORE_CLK_HZ / `LOGIC_CLK_HZ)
`define US_TO_TICKS(u) (((u) * `LOGIC_CLK_HZ + 999999) / 1000000)

`define UNDERVOLT_DEBOUNCE_SELECT_00_US 5
`define UNDERVOLT_DEBOUNCE_SELECT_01_US 15
`define UNDERVOLT_DEBOUNCE_SELECT_10_US 30
`define UNDERVOLT_DEBOUNCE_SELECT_11_US 40
`define OVERVOLT_DEBOUNCE_SELECT_00_US 30
`define OVERVOLT_DEBOUNCE_SELECT_01_US 50
`define OVERVOLT_DEBOUNCE_SELECT_10_US 80
`define OVERVOLT_DEBOUNCE_SELECT_11_US 125

`define OFS_CTRL 8'h00
`define OFS_MON_EN 8'h04
`define OFS_THRESH 8'h08
`define OFS_STATUS 8'h0c
`define OFS_EVENT 8'h10
`define OFS_MASK 8'h14
`define OFS_KEY 8'h18

`define CTRL_UVDB_LSB 0
`define CTRL_OVDB_LSB 2
`define CTRL_SECURE_BIT 4
`define THRESH_OV_LSB 8
`define STATUS_OV_LSB 4
`define STATUS_BLANK_LSB 8

`define UNDERVOLT_DEBOUNCE_SELECT_RESET 2'h2
`define OVERVOLT_DEBOUNCE_SELECT_RESET 2'h0
`define MON_EN_RESET 4'hf
`define SECURE_KEY 32'h0000a5c3

`endif

// ### logic/regmon_pkg.sv
// types shared by the regulator voltage monitor modules
package regmon_pkg;
   typedef struct packed {
      logic [7:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;

   typedef struct packed {
      logic [8:0] div;
      logic tick;
   } tick_state_s;

   typedef struct packed {
      logic [3:0] count;
      logic status;
   } deb_state_s;

   typedef struct packed {
      apb_rsp_s rsp;
      logic [1:0] undervolt_debounce_select;
      logic [1:0] overvolt_debounce_select;
      logic secure_en;
      logic key_armed;
      logic [3:0] mon_en;
      logic [7:0] uv_th;
      logic [7:0] ov_th;
      logic defaults_loaded;
      logic [3:0] uv_s1;
      logic [3:0] uv_s2;
      logic [3:0] ov_s1;
      logic [3:0] ov_s2;
      logic [3:0] ren_s1;
      logic [3:0] ren_s2;
      logic [3:0] inreg_s1;
      logic [3:0] inreg_s2;
      logic [3:0] blank;
      logic [3:0] uv_prev;
      logic [3:0] ov_prev;
      logic [7:0] event_flags;
      logic [7:0] mask;
      logic irq;
      logic [3:0] mon_active;
   } top_state_s;
endpackage

// ### logic/logic_tick_gen.sv
// 100 kHz logic tick enable derived from the core clock
`timescale 1ns/1ps
`include "regmon_map.svh"
module logic_tick_gen (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // tick
   output logic o_tick
);
   import regmon_pkg::*;
   localparam logic [8:0] DIV_LAST = 9'(`TICK_DIV - 1);
   tick_state_s s_r;
   tick_state_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (s_r.div == DIV_LAST) begin
         s_nxt.div = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.div = s_r.div + 9'h001;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_tick = s_r.tick;
endmodule

// ### logic/debounce_timer.sv
// debounce of one raw comparator output, counted in logic ticks
`timescale 1ns/1ps
module debounce_timer (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // timing
   input wire logic i_tick,
   input wire logic [3:0] i_limit,
   // comparator and gating
   input wire logic i_raw,
   input wire logic i_active,
   // result
   output logic o_status
);
   import regmon_pkg::*;
   deb_state_s s_r;
   deb_state_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (!i_active) begin
         s_nxt = '0;
      end else if (!i_raw) begin
         s_nxt = '0;
      end else if (i_tick && !s_r.status) begin
         // tick phase is free running, so the first count may come early by up to one tick
         s_nxt.count = s_r.count + 4'h1;
         if (s_r.count + 4'h1 >= i_limit) begin
            s_nxt.status = 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_status = s_r.status;
endmodule

// ### logic/regulator_voltage_monitor.sv
// regulator voltage monitor: apb registers, comparator interface, debounce and events
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "regmon_map.svh"
module regulator_voltage_monitor (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // apb slave
   input wire regmon_pkg::apb_req_s i_apb,
   output regmon_pkg::apb_rsp_s o_apb,
   // threshold defaults from configuration memory
   input wire logic [1:0] i_buck_undervolt_threshold_default,
   input wire logic [1:0] i_linear_undervolt_threshold_default,
   input wire logic [1:0] i_buck_overvolt_threshold_default,
   input wire logic [1:0] i_linear_overvolt_threshold_default,
   // regulator state, ch0 buck_one, ch1 buck_two, ch2 buck_three, ch3 linear_regulator_one
   input wire logic [3:0] i_regulator_on,
   input wire logic [3:0] i_in_regulation,
   // analog comparators
   input wire logic [3:0] i_uv_raw,
   input wire logic [3:0] i_ov_raw,
   output logic [7:0] o_uv_threshold_code,
   output logic [7:0] o_ov_threshold_code,
   output logic [3:0] o_monitor_active,
   // status and interrupt
   output logic [3:0] o_undervolt_status,
   output logic [3:0] o_overvolt_status,
   output logic o_irq
);
   import regmon_pkg::*;

   top_state_s s_r;
   top_state_s s_nxt;
   logic tick;
   logic [3:0] uv_stat;
   logic [3:0] ov_stat;
   logic [3:0] uv_limit;
   logic [3:0] ov_limit;

   function automatic logic [3:0] uv_ticks(input logic [1:0] sel);
      logic [3:0] t;
      t = 4'(`US_TO_TICKS(`UNDERVOLT_DEBOUNCE_SELECT_11_US));
      case (sel)
         2'h0: t = 4'(`US_TO_TICKS(`UNDERVOLT_DEBOUNCE_SELECT_00_US));
         2'h1: t = 4'(`US_TO_TICKS(`UNDERVOLT_DEBOUNCE_SELECT_01_US));
         2'h2: t = 4'(`US_TO_TICKS(`UNDERVOLT_DEBOUNCE_SELECT_10_US));
         default: t = 4'(`US_TO_TICKS(`UNDERVOLT_DEBOUNCE_SELECT_11_US));
      endcase
      return t;
   endfunction

   function automatic logic [3:0] ov_ticks(input logic [1:0] sel);
      logic [3:0] t;
      t = 4'(`US_TO_TICKS(`OVERVOLT_DEBOUNCE_SELECT_11_US));
      case (sel)
         2'h0: t = 4'(`US_TO_TICKS(`OVERVOLT_DEBOUNCE_SELECT_00_US));
         2'h1: t = 4'(`US_TO_TICKS(`OVERVOLT_DEBOUNCE_SELECT_01_US));
         2'h2: t = 4'(`US_TO_TICKS(`OVERVOLT_DEBOUNCE_SELECT_10_US));
         default: t = 4'(`US_TO_TICKS(`OVERVOLT_DEBOUNCE_SELECT_11_US));
      endcase
      return t;
   endfunction

   assign uv_limit = uv_ticks(s_r.undervolt_debounce_select);
   assign ov_limit = ov_ticks(s_r.overvolt_debounce_select);

   logic_tick_gen u_tick (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .o_tick(tick)
   );

   // one uv and one ov debouncer per supervised channel
   genvar ch;
   generate
      for (ch = 0; ch < `NUM_CH; ch++) begin : g_ch
         debounce_timer u_uv (
            .i_core_clk(i_core_clk),
            .i_reset(i_reset),
            .i_tick(tick),
            .i_limit(uv_limit),
            .i_raw(s_r.uv_s2[ch]),
            .i_active(s_r.mon_active[ch]),
            .o_status(uv_stat[ch])
         );
         debounce_timer u_ov (
            .i_core_clk(i_core_clk),
            .i_reset(i_reset),
            .i_tick(tick),
            .i_limit(ov_limit),
            .i_raw(s_r.ov_s2[ch]),
            .i_active(s_r.mon_active[ch]),
            .o_status(ov_stat[ch])
         );
      end
   endgenerate

   always_comb begin
      logic access;
      logic done;
      logic wr;
      logic rd;
      logic [7:0] rise;
      logic [7:0] clr;
      logic [31:0] rdata;
      logic hit;
      access = i_apb.psel && i_apb.penable;
      done = access && s_r.rsp.pready;
      wr = done && i_apb.pwrite;
      rd = done && !i_apb.pwrite;
      rise = '0;
      clr = '0;
      rdata = '0;
      hit = 1'b1;
      s_nxt = s_r;

      // two-flop synchronisers for analog and regulator inputs
      s_nxt.uv_s1 = i_uv_raw;
      s_nxt.uv_s2 = s_r.uv_s1;
      s_nxt.ov_s1 = i_ov_raw;
      s_nxt.ov_s2 = s_r.ov_s1;
      s_nxt.ren_s1 = i_regulator_on;
      s_nxt.ren_s2 = s_r.ren_s1;
      s_nxt.inreg_s1 = i_in_regulation;
      s_nxt.inreg_s2 = s_r.inreg_s1;

      // thresholds load once after reset release, so straps are never read under reset
      if (!s_r.defaults_loaded) begin
         s_nxt.defaults_loaded = 1'b1;
         s_nxt.uv_th = {i_linear_undervolt_threshold_default,
                        {3{i_buck_undervolt_threshold_default}}};
         s_nxt.ov_th = {i_linear_overvolt_threshold_default,
                        {3{i_buck_overvolt_threshold_default}}};
      end

      // a regulator that is off, or just switched on, stays blanked until in regulation
      s_nxt.blank = ~s_r.ren_s2 | (s_r.blank & ~s_r.inreg_s2);
      s_nxt.mon_active = s_r.mon_en & s_r.ren_s2 & ~s_r.blank;

      // register decode and read data
      case (i_apb.paddr)
         `OFS_CTRL: begin
            rdata[`CTRL_UVDB_LSB +: 2] = s_r.undervolt_debounce_select;
            rdata[`CTRL_OVDB_LSB +: 2] = s_r.overvolt_debounce_select;
            rdata[`CTRL_SECURE_BIT] = s_r.secure_en;
         end
         `OFS_MON_EN: rdata[3:0] = s_r.mon_en;
         `OFS_THRESH: begin
            rdata[7:0] = s_r.uv_th;
            rdata[`THRESH_OV_LSB +: 8] = s_r.ov_th;
         end
         `OFS_STATUS: begin
            rdata[3:0] = uv_stat;
            rdata[`STATUS_OV_LSB +: 4] = ov_stat;
            rdata[`STATUS_BLANK_LSB +: 4] = s_r.blank;
         end
         `OFS_EVENT: rdata[7:0] = s_r.event_flags;
         `OFS_MASK: rdata[7:0] = s_r.mask;
         `OFS_KEY: rdata = '0;
         default: hit = 1'b0;
      endcase

      // one wait state: pready rises in the second access cycle
      s_nxt.rsp.pready = access && !s_r.rsp.pready;
      if (access && !s_r.rsp.pready) begin
         s_nxt.rsp.prdata = i_apb.pwrite ? 32'h00000000 : rdata;
         s_nxt.rsp.pslverr = !hit;
      end else begin
         s_nxt.rsp.prdata = '0;
         s_nxt.rsp.pslverr = 1'b0;
      end

      // writes take effect on the completing edge only
      if (wr && hit) begin
         s_nxt.key_armed = 1'b0;
         case (i_apb.paddr)
            `OFS_CTRL: begin
               s_nxt.undervolt_debounce_select = i_apb.pwdata[`CTRL_UVDB_LSB +: 2];
               s_nxt.overvolt_debounce_select = i_apb.pwdata[`CTRL_OVDB_LSB +: 2];
               s_nxt.secure_en = i_apb.pwdata[`CTRL_SECURE_BIT];
            end
            `OFS_MON_EN: begin
               // protected: a plain write is dropped silently while protection is on
               if (!s_r.secure_en || s_r.key_armed) begin
                  s_nxt.mon_en = i_apb.pwdata[3:0];
               end
            end
            `OFS_THRESH: begin
               s_nxt.uv_th = i_apb.pwdata[7:0];
               s_nxt.ov_th = i_apb.pwdata[`THRESH_OV_LSB +: 8];
            end
            `OFS_MASK: s_nxt.mask = i_apb.pwdata[7:0];
            `OFS_KEY: s_nxt.key_armed = (i_apb.pwdata == `SECURE_KEY);
            default: s_nxt.key_armed = 1'b0;
         endcase
      end

      // events: rising debounced status, cleared by reading, a new event wins the clear
      s_nxt.uv_prev = uv_stat;
      s_nxt.ov_prev = ov_stat;
      rise = {ov_stat & ~s_r.ov_prev, uv_stat & ~s_r.uv_prev};
      if (rd && i_apb.paddr == `OFS_EVENT) begin
         clr = 8'hff;
      end
      s_nxt.event_flags = (s_r.event_flags & ~clr) | rise;
      s_nxt.irq = |(s_nxt.event_flags & s_r.mask);
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         s_r <= '0;
         s_r.undervolt_debounce_select <= `UNDERVOLT_DEBOUNCE_SELECT_RESET;
         s_r.overvolt_debounce_select <= `OVERVOLT_DEBOUNCE_SELECT_RESET;
         s_r.mon_en <= `MON_EN_RESET;
         s_r.blank <= 4'hf;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_apb = s_r.rsp;
   assign o_uv_threshold_code = s_r.uv_th;
   assign o_ov_threshold_code = s_r.ov_th;
   assign o_monitor_active = s_r.mon_active;
   assign o_undervolt_status = uv_stat;
   assign o_overvolt_status = ov_stat;
   assign o_irq = s_r.irq;
endmodule

// ### tb/regmon_properties.sv
// port assertions for the regulator voltage monitor
`timescale 1ns/1ps
module regmon_properties (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // apb
   input wire regmon_pkg::apb_req_s i_apb,
   input wire regmon_pkg::apb_rsp_s o_apb,
   // straps and regulators
   input wire logic [1:0] i_buck_undervolt_threshold_default,
   input wire logic [1:0] i_linear_undervolt_threshold_default,
   input wire logic [1:0] i_buck_overvolt_threshold_default,
   input wire logic [1:0] i_linear_overvolt_threshold_default,
   input wire logic [3:0] i_regulator_on,
   // comparators and status
   input wire logic [3:0] i_uv_raw,
   input wire logic [3:0] i_ov_raw,
   input wire logic [7:0] o_uv_threshold_code,
   input wire logic [7:0] o_ov_threshold_code,
   input wire logic [3:0] o_monitor_active,
   input wire logic [3:0] o_undervolt_status,
   input wire logic [3:0] o_overvolt_status
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   chk_apb_wait: assert property ($rose(i_apb.penable) && i_apb.psel |=> o_apb.pready)
      else $error("pready missing after one wait state");
   chk_ready_pulse: assert property (o_apb.pready |=> !o_apb.pready)
      else $error("pready held longer than one cycle");
   chk_err_ready: assert property (o_apb.pslverr |-> o_apb.pready && o_apb.prdata == 32'h0)
      else $error("error response malformed");
   chk_thresh_load: assert property ($past(i_reset) && !i_reset |=>
      o_uv_threshold_code == {i_linear_undervolt_threshold_default,
      {3{i_buck_undervolt_threshold_default}}} && o_ov_threshold_code ==
      {i_linear_overvolt_threshold_default, {3{i_buck_overvolt_threshold_default}}})
      else $error("threshold defaults not loaded");
   // raw must still be high this far back or the count would have restarted
   chk_uv_debounce: assert property (
      !(|(o_undervolt_status & ~$past(o_undervolt_status) & ~$past(i_uv_raw, 3))))
      else $error("undervolt status rose without raw input");
   chk_ov_debounce: assert property (
      !(|(o_overvolt_status & ~$past(o_overvolt_status) & ~$past(i_ov_raw, 300))))
      else $error("overvolt status rose before debounce");
   chk_active_rise: assert property (
      !(|(o_monitor_active & ~$past(o_monitor_active) & ~$past(i_regulator_on, 3))))
      else $error("monitor active with regulator off");
   chk_status_off: assert property (!(|((o_undervolt_status | o_overvolt_status) &
      ~o_monitor_active & ~$past(o_monitor_active) & ~$past(o_monitor_active, 2))))
      else $error("status set on inactive channel");
endmodule
bind regulator_voltage_monitor regmon_properties chk_u (.i_core_clk, .i_reset, .i_apb,
   .o_apb, .i_buck_undervolt_threshold_default, .i_linear_undervolt_threshold_default,
   .i_buck_overvolt_threshold_default, .i_linear_overvolt_threshold_default,
   .i_regulator_on, .i_uv_raw, .i_ov_raw, .o_uv_threshold_code, .o_ov_threshold_code,
   .o_monitor_active, .o_undervolt_status, .o_overvolt_status);

// ### tb/comparator_model.sv
// behavioural analog comparators of the four regulators
`timescale 1ns/1ps
module comparator_model (
   // output levels in percent of nominal
   input int i_level [4],
   // threshold codes
   input wire logic [7:0] i_uv_code,
   input wire logic [7:0] i_ov_code,
   // raw outputs
   output logic [3:0] o_uv_raw,
   output logic [3:0] o_ov_raw
);
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         o_uv_raw[c] = i_level[c] < 95 - 2 * int'(i_uv_code[2*c +: 2]);
         o_ov_raw[c] = i_level[c] > 105 + 2 * int'(i_ov_code[2*c +: 2]);
      end
   end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the regulator voltage monitor
`timescale 1ns/1ps
`include "regmon_map.svh"
module tb_top;
   import regmon_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_reset = 1'b1;
   apb_req_s apb_r = '0;
   apb_rsp_s o_apb;
   logic [1:0] buv, luv, bov, lov;
   logic [3:0] ron = 4'hf, inreg = 4'hf, uvr, ovr, act, uvs, ovs;
   logic [7:0] uvc, ovc;
   logic irq, er;
   logic [31:0] rd;
   int lvl [4] = '{100, 100, 100, 100};
   int lim [8] = '{1, 2, 3, 4, 3, 5, 8, 13};
   int err_count = 0;
   int n_checks = 0;
   int seed = 32'hc744;
   int n;
   always #12.5 i_core_clk = ~i_core_clk;
   regulator_voltage_monitor dut_u (.i_core_clk, .i_reset, .i_apb(apb_r), .o_apb,
      .i_buck_undervolt_threshold_default(buv), .i_linear_undervolt_threshold_default(luv),
      .i_buck_overvolt_threshold_default(bov), .i_linear_overvolt_threshold_default(lov),
      .i_regulator_on(ron), .i_in_regulation(inreg), .i_uv_raw(uvr), .i_ov_raw(ovr),
      .o_uv_threshold_code(uvc), .o_ov_threshold_code(ovc), .o_monitor_active(act),
      .o_undervolt_status(uvs), .o_overvolt_status(ovs), .o_irq(irq));
   comparator_model cmp_u (.i_level(lvl), .i_uv_code(uvc), .i_ov_code(ovc), .o_uv_raw(uvr),
      .o_ov_raw(ovr));
   task automatic finish_test;
      if (err_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_win(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   // no fixed latency assumed: wait for pready under a bound
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge i_core_clk);
      apb_r <= '{a, 1'b1, 1'b0, w, d};
      @(posedge i_core_clk);
      apb_r.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge i_core_clk);
         k++;
      end while (o_apb.pready !== 1'b1 && k < 20);
      if (o_apb.pready !== 1'b1) begin
         err_count++;
         finish_test();
      end
      rd = o_apb.prdata;
      er = o_apb.pslverr;
      apb_r.psel <= 1'b0;
      apb_r.penable <= 1'b0;
   endtask
   task automatic wait_st(input int ch, input logic ov, output int c);
      c = 0;
      do begin
         @(posedge i_core_clk);
         c++;
      end while ((ov ? ovs[ch] : uvs[ch]) !== 1'b1 && c < 6000);
      if (c >= 6000) begin
         err_count++;
         finish_test();
      end
   endtask
   task automatic rst_chk;
      bus(8'h00, 1'b0, 32'h0);
      chk(rd, 32'h2);
      bus(8'h04, 1'b0, 32'h0);
      chk(rd, 32'hf);
      chk({ovc, uvc}, {lov, {3{bov}}, luv, {3{buv}}});
   endtask
   initial begin
      {buv, luv, bov, lov} <= 8'($random(seed));
      repeat (16) @(posedge i_core_clk);
      i_reset <= 1'b0;
      rst_chk();
      bus(8'h1c, 1'b0, 32'h0);
      chk({31'h0, er}, 32'h1);
      n = $random(seed);
      bus(8'h08, 1'b1, {16'h0, n[15:0]});
      repeat (2) @(posedge i_core_clk);
      chk({ovc, uvc}, n[15:0]);
      bus(8'h14, 1'b1, 32'hff);
      // every debounce code of both fields on channel one
      for (int i = 0; i < 8; i++) begin
         bus(8'h00, 1'b1, (i < 4) ? i : (i - 4) << 2);
         lvl[1] <= (i < 4) ? 80 : 120;
         wait_st(1, i > 3, n);
         chk_win(n, (lim[i] - 1) * 400, lim[i] * 400 + 8);
         repeat (2) @(posedge i_core_clk);
         chk({31'h0, irq}, 32'h1);
         bus(8'h0c, 1'b0, 32'h0);
         chk(rd, (i < 4) ? 32'h2 : 32'h20);
         bus(8'h10, 1'b0, 32'h0);
         chk(rd, (i < 4) ? 32'h2 : 32'h20);
         lvl[1] <= 100;
         repeat (5) @(posedge i_core_clk);
         chk({31'h0, irq}, 32'h0);
      end
      // ch1 uv masked off: the flag still latches but the interrupt stays low
      bus(8'h14, 1'b1, 32'hfd);
      lvl[1] <= 80;
      wait_st(1, 1'b0, n);
      repeat (2) @(posedge i_core_clk);
      chk({31'h0, irq}, 32'h0);
      bus(8'h10, 1'b0, 32'h0);
      chk(rd, 32'h2);
      bus(8'h00, 1'b1, 32'h1c);
      bus(8'h18, 1'b1, ~`SECURE_KEY);
      bus(8'h04, 1'b1, 32'h0);
      bus(8'h04, 1'b0, 32'h0);
      chk(rd, 32'hf);
      bus(8'h18, 1'b1, `SECURE_KEY);
      bus(8'h04, 1'b1, 32'hd);
      bus(8'h04, 1'b0, 32'h0);
      chk(rd, 32'hd);
      repeat (3) @(posedge i_core_clk);
      chk({act, uvs}, 8'hd0);
      // blanked until the regulator reports regulation
      ron[2] <= 1'b0;
      inreg[2] <= 1'b0;
      repeat (8) @(posedge i_core_clk);
      ron[2] <= 1'b1;
      lvl[2] <= 80;
      repeat (1000) @(posedge i_core_clk);
      chk({act[2], uvs[2]}, 32'h0);
      bus(8'h0c, 1'b0, 32'h0);
      chk(rd, 32'h400);
      inreg[2] <= 1'b1;
      wait_st(2, 1'b0, n);
      chk_win(n, 3, 420);
      repeat (2) @(posedge i_core_clk);
      chk({31'h0, irq}, 32'h1);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_reset <= 1'b0;
      rst_chk();
      finish_test();
   end
endmodule
